// >>> hw/aspr_top.sv
// Purpose: asynchronous serial port with AHB-Lite register slave
// Assumes: zero-wait slave, pins synchronous to mclk_i
// Notes: 4-deep character queues each way
`timescale 1ns/100ps
`default_nettype none
`include "aspr_map.svh"

// Operation
// - idle_stop set halts port during Idle, except an auto-rate count already in progress
// - codec enable routes data through pulse codec
// - sleep wake on falling edge, bit self-clears
// - auto-rate measures 55h field with codec off, then self-clears
// - tx_irq_select picks transmit interrupt moment
// - tx_idle_polarity sets idle level, codec reverses
// - tx_buffer_full reads 1 when queue full
// - received character bits 8-0, upper zero
// - transmit character write-only, nine bits queued
module aspr_top (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic idle_i,
  input wire logic sleep_i,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic irq_o
);
  aspr_pkg::aspr_st_s s_ff;
  aspr_pkg::aspr_st_s nxt_s;
  logic run, tick, nine, ir, raw, rxbit, fall, load, done, ap;
  logic wr_tx, pop_tx, push_rx, rd_rx;
  logic [4:0] len, half, ev;
  logic [3:0] nd;
  logic [9:0] newsh;
  logic [19:0] abq;
  aspr_pkg::aspr_chr_t chr;
  logic [15:0] sta;

  function automatic logic [4:0] osr(input logic hs);
    osr = hs ? `ASPR_OSR_HI : `ASPR_OSR_LO;
  endfunction
  function automatic logic [1:0] fidx(input logic [1:0] r, input logic [2:0] n);
    fidx = r + n[1:0];
  endfunction
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    ev = 5'h00;
    wr_tx = 1'b0;
    pop_tx = 1'b0;
    push_rx = 1'b0;
    rd_rx = 1'b0;
    done = 1'b0;
    chr = s_ff.txq[s_ff.txr];
    run = s_ff.mode[`ASPR_M_ON] && !(idle_i && s_ff.mode[`ASPR_M_SIDL]) && !sleep_i;
    tick = run && (s_ff.pre == 16'h0000);
    nine = s_ff.mode[`ASPR_M_NINE];
    ir = s_ff.mode[`ASPR_M_IR];
    len = osr(s_ff.mode[`ASPR_M_RATE_GEN_HIGH_SPEED]);
    half = len >> 1;
    nd = nine ? 4'h9 : 4'h8;
    sta = {s_ff.txisel[1], s_ff.txinv, s_ff.txisel[0], s_ff.rxen, s_ff.txbrk,
           s_ff.txen, s_ff.txn == `ASPR_DEPTH,
           !s_ff.txbusy && s_ff.txn == 3'h0,
           6'h00, s_ff.rx_overrun, s_ff.rxn != 3'h0};
    if (run) begin
      nxt_s.pre = tick ? s_ff.brg : s_ff.pre - 16'h0001;
    end
    // ****************************************
    // register slave
    // ****************************************
    ap = hsel_i && hready_i && htrans_i[1];
    nxt_s.dph = ap;
    nxt_s.dwr = hwrite_i;
    nxt_s.dadr = haddr_i[4:0];
    if (ap && !hwrite_i) begin
      unique case (haddr_i[4:0])
        `ASPR_A_MODE: nxt_s.rdata = s_ff.mode;
        `ASPR_A_STA: nxt_s.rdata = sta;
        `ASPR_A_RXC: begin
          nxt_s.rdata = {7'h00, s_ff.rxq[s_ff.rxr]};
          rd_rx = s_ff.rxn != 3'h0;
        end
        `ASPR_A_IST: nxt_s.rdata = {11'h000, s_ff.ist};
        `ASPR_A_IEN: nxt_s.rdata = {11'h000, s_ff.ien};
        `ASPR_A_BRG: nxt_s.rdata = s_ff.brg;
        default: nxt_s.rdata = 16'h0000;
      endcase
    end
    if (s_ff.dph && s_ff.dwr) begin
      unique case (s_ff.dadr)
        `ASPR_A_MODE: nxt_s.mode = hwdata_i[15:0];
        `ASPR_A_STA: begin
          nxt_s.txisel = {hwdata_i[15], hwdata_i[13]};
          nxt_s.txinv = hwdata_i[14];
          nxt_s.rxen = hwdata_i[12];
          nxt_s.txbrk = hwdata_i[11];
          nxt_s.txen = hwdata_i[10];
          if (!hwdata_i[1]) begin
            nxt_s.rx_overrun = 1'b0;
          end
        end
        `ASPR_A_TXC: wr_tx = s_ff.txn != `ASPR_DEPTH;
        `ASPR_A_ICLR: nxt_s.ist = s_ff.ist & ~hwdata_i[4:0];
        `ASPR_A_IEN: nxt_s.ien = hwdata_i[4:0];
        `ASPR_A_BRG: nxt_s.brg = hwdata_i[15:0];
        default: ;
      endcase
    end
    if (wr_tx) begin
      nxt_s.txq[fidx(s_ff.txr, s_ff.txn)] = hwdata_i[8:0];
    end
    // ****************************************
    // transmitter
    // ****************************************
    raw = s_ff.txbusy ? s_ff.txsh[0] : 1'b1;
    load = run && s_ff.txen && !s_ff.txbusy && (s_ff.txbrk || s_ff.txn != 3'h0);
    if (load) begin
      nxt_s.txbusy = 1'b1;
      nxt_s.txsub = 5'h00;
      if (s_ff.txbrk) begin
        nxt_s.txsh = `ASPR_BRK_FRAME;
        nxt_s.txbits = `ASPR_BRK_BITS;
        nxt_s.txbrka = 1'b1;
      end else begin
        nxt_s.txsh = {4'hF, nine ? chr : {1'b1, chr[7:0]}, 1'b0};
        nxt_s.txbits = nine ? 4'hB : 4'hA;
        nxt_s.txr = s_ff.txr + 2'h1;
        pop_tx = 1'b1;
      end
    end else if (s_ff.txbusy && tick) begin
      if (s_ff.txsub == len - 5'h01) begin
        nxt_s.txsub = 5'h00;
        nxt_s.txsh = {1'b1, s_ff.txsh[13:1]};
        nxt_s.txbits = s_ff.txbits - 4'h1;
        if (s_ff.txbits == 4'h1) begin
          nxt_s.txbusy = 1'b0;
          done = 1'b1;
          if (s_ff.txbrka) begin
            nxt_s.txbrka = 1'b0;
            nxt_s.txbrk = 1'b0;
          end
        end
      end else begin
        nxt_s.txsub = s_ff.txsub + 5'h01;
      end
    end
    unique case (s_ff.txisel)
      2'b00: ev[`ASPR_I_TX] = pop_tx;
      2'b01: ev[`ASPR_I_TX] = done && s_ff.txn == 3'h0;
      2'b10: ev[`ASPR_I_TX] = pop_tx && s_ff.txn == 3'h1;
      2'b11: ev[`ASPR_I_TX] = 1'b0;
    endcase
    // encoder pulses early in each zero bit; idle level then inverts with polarity
    if (ir) begin
      nxt_s.txo = (!raw && s_ff.txbusy && s_ff.txsub < `ASPR_IR_PULSE) ^ s_ff.txinv;
    end else begin
      nxt_s.txo = raw ^ s_ff.txinv;
    end
    // ****************************************
    // receiver
    // ****************************************
    // decoder holds a seen pulse for the rest of the bit so mid-bit sampling works
    rxbit = ir ? !(serial_in_pin_i || s_ff.seen) : serial_in_pin_i;
    fall = s_ff.rxprev && !rxbit;
    newsh = {rxbit, s_ff.rxsh[9:1]};
    abq = s_ff.mode[`ASPR_M_RATE_GEN_HIGH_SPEED] ? ((s_ff.abcnt + 20'h00001) >> `ASPR_ABD_SH_HI)
                                  : ((s_ff.abcnt + 20'h00001) >> `ASPR_ABD_SH_LO);
    nxt_s.rxprev = rxbit;
    nxt_s.pinprev = serial_in_pin_i;
    nxt_s.seen = s_ff.seen | (ir && serial_in_pin_i);
    if (sleep_i && s_ff.mode[`ASPR_M_WAKE] && s_ff.pinprev && !serial_in_pin_i) begin
      nxt_s.mode[`ASPR_M_WAKE] = 1'b0;
      ev[`ASPR_I_WAKE] = 1'b1;
    end
    unique case (s_ff.rxst)
      aspr_pkg::RX_IDLE: begin
        nxt_s.seen = 1'b0;
        if (run && s_ff.rxen) begin
          if (s_ff.mode[`ASPR_M_ABD]) begin
            nxt_s.rxst = aspr_pkg::RX_ABD;
            nxt_s.abedge = 3'h0;
            nxt_s.abcnt = 20'h00000;
          end else if (fall) begin
            nxt_s.rxst = aspr_pkg::RX_START;
            nxt_s.rxsub = 5'h00;
            nxt_s.seen = ir;
          end
        end
      end
      aspr_pkg::RX_START: begin
        if (tick) begin
          if (s_ff.rxsub == half && rxbit) begin
            nxt_s.rxst = aspr_pkg::RX_IDLE;
          end else if (s_ff.rxsub == len - 5'h01) begin
            nxt_s.rxst = aspr_pkg::RX_DATA;
            nxt_s.rxsub = 5'h00;
            nxt_s.rxbits = 4'h0;
            nxt_s.seen = 1'b0;
          end else begin
            nxt_s.rxsub = s_ff.rxsub + 5'h01;
          end
        end
      end
      aspr_pkg::RX_DATA: begin
        if (tick) begin
          nxt_s.rxsub = s_ff.rxsub + 5'h01;
          if (s_ff.rxsub == half) begin
            nxt_s.rxsh = newsh;
            if (s_ff.rxbits == nd) begin
              nxt_s.rxst = aspr_pkg::RX_IDLE;
              if (s_ff.rxn == `ASPR_DEPTH) begin
                nxt_s.rx_overrun = 1'b1;
                ev[`ASPR_I_RX_OVERRUN] = 1'b1;
              end else begin
                nxt_s.rxq[fidx(s_ff.rxr, s_ff.rxn)] = nine ? newsh[8:0] : {1'b0, newsh[8:1]};
                push_rx = 1'b1;
                ev[`ASPR_I_RX] = 1'b1;
              end
            end
          end else if (s_ff.rxsub == len - 5'h01) begin
            nxt_s.rxsub = 5'h00;
            nxt_s.rxbits = s_ff.rxbits + 4'h1;
            nxt_s.seen = 1'b0;
          end
        end
      end
      aspr_pkg::RX_ABD: begin
        // sync field 55h gives five falling edges spanning eight bit times
        if (s_ff.abedge != 3'h0) begin
          nxt_s.abcnt = s_ff.abcnt + 20'h00001;
        end
        if (fall) begin
          nxt_s.abedge = s_ff.abedge + 3'h1;
          if (s_ff.abedge == 3'h4) begin
            nxt_s.brg = abq[15:0] - 16'h0001;
            nxt_s.mode[`ASPR_M_ABD] = 1'b0;
            ev[`ASPR_I_ABD] = 1'b1;
            nxt_s.rxst = aspr_pkg::RX_IDLE;
          end
        end
      end
    endcase

    // ****************************************
    // queue counts and sticky status
    // ****************************************
    nxt_s.txn = s_ff.txn + {2'h0, wr_tx} - {2'h0, pop_tx};
    nxt_s.rxn = s_ff.rxn + {2'h0, push_rx} - {2'h0, rd_rx};
    if (rd_rx) begin
      nxt_s.rxr = s_ff.rxr + 2'h1;
    end
    // set after clear so a same-cycle event survives
    nxt_s.ist = nxt_s.ist | ev;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff <= '0;
      s_ff.txo <= 1'b1;
      s_ff.rxprev <= 1'b1;
      s_ff.pinprev <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign hrdata_o = {16'h0000, s_ff.rdata};
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign serial_out_pin_o = s_ff.txo;
  assign irq_o = |(s_ff.ist & s_ff.ien);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_idle_halt: assert property (
    idle_i && s_ff.mode[`ASPR_M_SIDL] |=> $stable(s_ff.txsub) && $stable(s_ff.rxsub)
  ) else $error("port advanced while halted in idle");

  a_wake_clear: assert property (
    sleep_i && s_ff.mode[`ASPR_M_WAKE] && s_ff.pinprev && !serial_in_pin_i && !s_ff.dph
    |=> !s_ff.mode[`ASPR_M_WAKE] && s_ff.ist[`ASPR_I_WAKE]
  ) else $error("wake edge not flagged or enable not cleared");

  a_txisel_rsvd: assert property (
    s_ff.txisel == 2'b11 && !s_ff.dph |=> !$rose(s_ff.ist[`ASPR_I_TX])
  ) else $error("transmit interrupt raised in reserved mode");

  a_idle_level: assert property (
    !s_ff.txbusy && !s_ff.mode[`ASPR_M_IR] && !s_ff.dph |=> s_ff.txo == !$past(s_ff.txinv)
  ) else $error("wrong idle level on serial output");

  a_break_hold: assert property (
    s_ff.txbrka && !s_ff.dph |=> s_ff.txbrk || !s_ff.txbusy
  ) else $error("break request cleared before break ended");

  a_full_flag: assert property (
    ap && !hwrite_i && haddr_i[4:0] == `ASPR_A_STA
    |=> s_ff.rdata[9] == ($past(s_ff.txn) == `ASPR_DEPTH)
  ) else $error("buffer full flag disagrees with queue");

  a_rx_upper: assert property (
    ap && !hwrite_i && haddr_i[4:0] == `ASPR_A_RXC |=> s_ff.rdata[15:9] == 7'h00
  ) else $error("received character upper bits not zero");

  a_shift_empty: assert property (
    ap && !hwrite_i && haddr_i[4:0] == `ASPR_A_STA
    |=> s_ff.rdata[8] == ($past(s_ff.txn) == 3'h0 && !$past(s_ff.txbusy))
  ) else $error("shift empty flag wrong");

  a_rx_overrun_sticky: assert property (
    s_ff.rx_overrun && !s_ff.dph |=> s_ff.rx_overrun
  ) else $error("overrun flag dropped without software clear");

  a_rxda_flag: assert property (
    push_rx && !rd_rx |=> s_ff.rxn != 3'h0
  ) else $error("data available not shown after receive");
endmodule
`default_nettype wire

// >>> pkg/aspr_map.svh
// Purpose: register offsets, field positions and counts of the serial port
// Assumes: one 32-bit aligned word per register
// Notes: offsets are byte addresses within the port window
`ifndef ASPR_MAP_SVH
`define ASPR_MAP_SVH
// ****************************************
// offsets
// ****************************************
`define ASPR_A_MODE 5'h00
`define ASPR_A_STA 5'h04
`define ASPR_A_RXC 5'h08
`define ASPR_A_TXC 5'h0C
`define ASPR_A_IST 5'h10
`define ASPR_A_ICLR 5'h14
`define ASPR_A_IEN 5'h18
`define ASPR_A_BRG 5'h1C
// ****************************************
// mode fields
// ****************************************
`define ASPR_M_ON 15
`define ASPR_M_SIDL 13
`define ASPR_M_IR 12
`define ASPR_M_WAKE 7
`define ASPR_M_ABD 5
`define ASPR_M_RATE_GEN_HIGH_SPEED 3
`define ASPR_M_NINE 1
// ****************************************
// interrupt status bits
// ****************************************
`define ASPR_I_TX 0
`define ASPR_I_RX 1
`define ASPR_I_WAKE 2
`define ASPR_I_RX_OVERRUN 3
`define ASPR_I_ABD 4
// ****************************************
// counts
// ****************************************
`define ASPR_OSR_LO 5'h10
`define ASPR_OSR_HI 5'h04
`define ASPR_IR_PULSE 5'h03
`define ASPR_DEPTH 3'h4
`define ASPR_BRK_BITS 4'hE
`define ASPR_BRK_FRAME 14'h2000
`define ASPR_ABD_SH_LO 7
`define ASPR_ABD_SH_HI 5
`endif

// >>> pkg/aspr_pkg.sv
// Purpose: types of the serial port
// Assumes: fixed queue depth of four characters
// Notes: all state lives in one packed struct
package aspr_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_ABD = 2'b11
  } aspr_rx_e;
  typedef logic [8:0] aspr_chr_t;
  typedef struct packed {
    logic [15:0] mode;
    logic [1:0] txisel;
    logic txinv;
    logic rxen;
    logic txbrk;
    logic txen;
    logic rx_overrun;
    logic [15:0] brg;
    logic [15:0] pre;
    logic [4:0] ist;
    logic [4:0] ien;
    aspr_chr_t [3:0] txq;
    aspr_chr_t [3:0] rxq;
    logic [1:0] txr;
    logic [1:0] rxr;
    logic [2:0] txn;
    logic [2:0] rxn;
    logic [13:0] txsh;
    logic [3:0] txbits;
    logic [4:0] txsub;
    logic txbusy;
    logic txbrka;
    logic txo;
    aspr_rx_e rxst;
    logic [9:0] rxsh;
    logic [3:0] rxbits;
    logic [4:0] rxsub;
    logic seen;
    logic rxprev;
    logic pinprev;
    logic [19:0] abcnt;
    logic [2:0] abedge;
    logic dph;
    logic dwr;
    logic [4:0] dadr;
    logic [15:0] rdata;
  } aspr_st_s;
endpackage

// >>> testbench/aspr_peer.sv
// Purpose: remote serial peer, sends frames and decodes the port's output
// Assumes: 8 data bits, one stop bit, line idles high
// Notes: a frame whose stop bit reads low is logged as 1FF (break)
`timescale 1ns/100ps
`default_nettype none
module aspr_peer (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic line_o
);
  int bit_clks = 16;
  logic [8:0] got_q[$];
  initial line_o = 1'b1;
  // ****************************************
  // transmit side
  // ****************************************
  task automatic send(input logic [7:0] chr);
    logic [9:0] fr;
    fr = {1'b1, chr, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      line_o <= fr[i];
      repeat (bit_clks - 1) @(posedge mclk_i);
    end
  endtask
  // ****************************************
  // receive side, mid-bit sampling
  // ****************************************
  initial begin : rx_loop
    logic [7:0] sh;
    forever begin
      @(negedge line_i);
      repeat (bit_clks / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge mclk_i);
        sh[i] = line_i;
      end
      repeat (bit_clks) @(posedge mclk_i);
      if (line_i === 1'b1) begin
        got_q.push_back({1'b0, sh});
      end else begin
        got_q.push_back(9'h1FF);
        @(posedge line_i);
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/async_serial_port_regs_test.sv
// Purpose: self-checking bench of the serial port over its register bus
// Assumes: zero-wait slave, divisor 0 gives 16 clocks a bit
// Notes: one peer stands on the serial pins
`timescale 1ns/100ps
`default_nettype none
`include "aspr_map.svh"
module async_serial_port_regs_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic tx_line;
  wire logic rx_line;
  wire logic irq;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [7:0] sent[$];
  initial forever #5 mclk = ~mclk;
  aspr_top i_dut (.mclk_i(mclk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .idle_i(idle), .sleep_i(sleep), .serial_in_pin_i(rx_line),
    .serial_out_pin_o(tx_line), .irq_o(irq));
  // pins assumed mapped before the port is switched on
  aspr_peer i_peer (.mclk_i(mclk), .line_i(tx_line), .line_o(rx_line));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic idle_lvl(input logic pol, input logic ir);
    return ir ? pol : ~pol;
  endfunction
  function automatic logic [31:0] abd_brg(input int clks);
    return 32'((clks * 8) >> 7) - 32'h1;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask
  task automatic wait_got(input int k);
    int n;
    for (n = 0; n < 8000 && i_peer.got_q.size() < k; n++) @(posedge mclk);
    if (n >= 8000) begin
      n_errors++;
      final_report();
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    void'($urandom(80));
    bus(0, `ASPR_A_STA, 0);
    check(rd, 32'h100);
    bus(0, `ASPR_A_RXC, 0);
    check(rd, 32'h0);
    bus(0, `ASPR_A_TXC, 0);
    check(rd, 32'h0);
    $display("test reset done");
    bus(1, `ASPR_A_MODE, 32'h8000);
    for (int i = 0; i < 5; i++) begin
      sent.push_back(8'($urandom));
      bus(1, `ASPR_A_TXC, {24'h0, sent[i]});
    end
    bus(0, `ASPR_A_STA, 0);
    check(rd[9:8], 2'b10);
    bus(1, `ASPR_A_STA, 32'h1400);
    wait_got(4);
    for (int i = 0; i < 4; i++) check(i_peer.got_q[i], {1'b0, sent[i]});
    repeat (40) @(posedge mclk);
    check(i_peer.got_q.size(), 4);
    bus(0, `ASPR_A_STA, 0);
    check(rd[9:8], 2'b01);
    bus(0, `ASPR_A_IST, 0);
    check(rd[0], 1'b1);
    $display("test transmit queue done");
    bus(1, `ASPR_A_ICLR, 32'h1F);
    sent.delete();
    for (int i = 0; i < 5; i++) begin
      sent.push_back(8'($urandom));
      i_peer.send(sent[i]);
    end
    bus(0, `ASPR_A_STA, 0);
    check(rd[1:0], 2'b11);
    check(irq, 1'b0);
    bus(1, `ASPR_A_IEN, 32'h2);
    bus(0, `ASPR_A_IEN, 0);
    check(irq, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(0, `ASPR_A_RXC, 0);
      check(rd, {24'h0, sent[i]});
    end
    bus(0, `ASPR_A_STA, 0);
    check(rd[1:0], 2'b10);
    bus(1, `ASPR_A_STA, 32'h1400);
    bus(1, `ASPR_A_ICLR, 32'h2);
    bus(0, `ASPR_A_STA, 0);
    check(rd[1:0], 2'b00);
    check(irq, 1'b0);
    $display("test receive overrun done");
    i_peer.got_q.delete();
    bus(1, `ASPR_A_STA, 32'h1C00);
    wait_got(1);
    check(i_peer.got_q[0], 9'h1FF);
    repeat (100) @(posedge mclk);
    bus(0, `ASPR_A_STA, 0);
    check(rd[11], 1'b0);
    $display("test break done");
    i_peer.got_q.delete();
    bus(1, `ASPR_A_MODE, 32'hA000);
    idle <= 1'b1;
    bus(1, `ASPR_A_TXC, 32'h5A);
    repeat (300) @(posedge mclk);
    check(i_peer.got_q.size(), 0);
    bus(1, `ASPR_A_MODE, 32'h8000);
    wait_got(1);
    check(i_peer.got_q[0], 9'h05A);
    idle <= 1'b0;
    $display("test idle stop done");
    bus(1, `ASPR_A_MODE, 32'h8020);
    i_peer.bit_clks = 48;
    i_peer.send(8'h55);
    repeat (40) @(posedge mclk);
    bus(0, `ASPR_A_MODE, 0);
    check(rd[5], 1'b0);
    bus(0, `ASPR_A_BRG, 0);
    check(rd, abd_brg(48));
    bus(0, `ASPR_A_IST, 0);
    check(rd[4], 1'b1);
    bus(1, `ASPR_A_BRG, 0);
    i_peer.bit_clks = 16;
    $display("test auto rate done");
    bus(1, `ASPR_A_MODE, 32'h8080);
    sleep <= 1'b1;
    i_peer.send(8'($urandom));
    bus(0, `ASPR_A_MODE, 0);
    check(rd[7], 1'b0);
    bus(0, `ASPR_A_IST, 0);
    check(rd[2], 1'b1);
    sleep <= 1'b0;
    $display("test wake done");
    for (int m = 1; m < 4; m++) begin
      i_peer.got_q.delete();
      bus(1, `ASPR_A_ICLR, 32'h1F);
      bus(1, `ASPR_A_STA, 32'h0400 | (m[1] ? 32'h8000 : 32'h0) | (m[0] ? 32'h2000 : 32'h0));
      bus(1, `ASPR_A_TXC, 32'h33);
      repeat (2) @(posedge mclk);
      bus(0, `ASPR_A_IST, 0);
      check(rd[0], m == 2);
      wait_got(1);
      repeat (40) @(posedge mclk);
      bus(0, `ASPR_A_IST, 0);
      check(rd[0], m != 3);
    end
    $display("test transmit irq select done");
    for (int k = 0; k < 4; k++) begin
      // high-speed select stays 0 while the codec is on
      bus(1, `ASPR_A_MODE, 32'h8000 + (k[1] ? 32'h1000 : 32'h0));
      bus(1, `ASPR_A_STA, 32'h0400 + (k[0] ? 32'h4000 : 32'h0));
      repeat (4) @(posedge mclk);
      check(tx_line, idle_lvl(k[0], k[1]));
    end
    $display("test idle polarity done");
    final_report();
  end
endmodule
`default_nettype wire
